// file: logic/t2w_pkg.sv
// Package: register map, field layout, mode codes and carrier types of the timer2 waveform block
//
// Functional notes
// - A nonzero output action field hands its pin to the compare output, except a PWM code 0,1 that does not toggle; zero leaves it with the port.
// - The pin driver is enabled only while the pin direction bit is set, whoever owns the pin.
// - In normal and clear-on-match modes action codes mean disconnect, toggle, clear and set on match.
// - In fast PWM channel A code 0,1 disconnects with top mode bit 0 and toggles on match with it 1.
// - In fast PWM code 1,0 clears on match and sets at bottom, code 1,1 sets on match and clears at bottom.
// - In fast PWM a compare value equal to TOP with the high action bit set ignores the match but still acts at bottom.
// - In phase-correct PWM code 1,0 clears on an up-count match and sets on a down-count match, 1,1 the reverse.
// - In phase-correct PWM channel A code 0,1 disconnects with top mode bit 0 and toggles on match with it 1.
// - In phase-correct PWM a compare value equal to TOP with the high action bit set ignores the match but acts at TOP.
// - Bits 3:2 of the output wave control register ignore writes and read as zero.
// - The two low waveform bits and the top mode bit form a 3-bit mode code, with codes 4 and 6 reserved.
// - Modes 0 and 2 update compare values at once and flag overflow at 0xff, TOP being 0xff or compare value A.
// - Modes 1 and 5 update at TOP and flag at bottom, modes 3 and 7 update at TOP and flag at MAX or TOP.
package t2w_pkg;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [7:0] T2W_OFS_WAVE_CTRL  = 8'h00; // timer2_output_wave_control
  localparam logic [7:0] T2W_OFS_CLK_CTRL   = 8'h04; // timer2_clock_force_control
  localparam logic [7:0] T2W_OFS_COUNT      = 8'h08;
  localparam logic [7:0] T2W_OFS_CMP_A      = 8'h0c;
  localparam logic [7:0] T2W_OFS_CMP_B      = 8'h10;
  localparam logic [7:0] T2W_OFS_IRQ_STAT   = 8'h14;
  localparam logic [7:0] T2W_OFS_IRQ_MASK   = 8'h18;
  localparam logic [7:0] T2W_OFS_PIN_CTRL   = 8'h1c;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int T2W_F_ACT_A     = 6;  // chan_a_output_action 7:6
  localparam int T2W_F_ACT_B     = 4;  // chan_b_output_action 5:4
  localparam int T2W_F_LOW_BITS  = 0;  // waveform_mode_low_bits 1:0
  localparam int T2W_F_TOP_BIT   = 3;  // waveform_mode_top_bit
  localparam int T2W_F_RUN       = 0;  // counter run enable
  localparam int T2W_F_DIR_A     = 0;  // pin direction A
  localparam int T2W_F_DIR_B     = 1;  // pin direction B
  localparam int T2W_F_PORT_A    = 2;  // port data A
  localparam int T2W_F_PORT_B    = 3;  // port data B
  localparam int T2W_F_IRQ_OVF   = 0;  // overflow_flag
  localparam int T2W_F_IRQ_MA    = 1;  // match A
  localparam int T2W_F_IRQ_MB    = 2;  // match B
  localparam logic [7:0] T2W_RST_BYTE = 8'h00;
  localparam logic [7:0] T2W_MAX      = 8'hff;
  localparam logic [7:0] T2W_BOTTOM   = 8'h00;

  // ****************************************************************
  // Mode classes and action codes
  // ****************************************************************
  typedef enum logic [1:0] {
    T2W_CLS_NONPWM = 2'b00,
    T2W_CLS_FAST   = 2'b01,
    T2W_CLS_PHASE  = 2'b10
  } t2w_class_e;

  localparam logic [1:0] T2W_ACT_OFF    = 2'b00;
  localparam logic [1:0] T2W_ACT_TOGGLE = 2'b01;
  localparam logic [1:0] T2W_ACT_CLEAR  = 2'b10;
  localparam logic [1:0] T2W_ACT_SET    = 2'b11;

  // Counter events handed to each channel
  typedef struct packed {
    logic tick;
    logic match;
    logic at_bottom;
    logic at_top;
    logic up;
    logic cmp_is_top;
  } t2w_ev_s;

endpackage

// file: logic/t2w_channel.sv
// Compare-output waveform unit for one channel
`timescale 1ns/1ps
`default_nettype none
module t2w_channel
  import t2w_pkg::*;
#(
  parameter bit IS_CHAN_A = 1'b1
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Control
  input  wire t2w_class_e cls,
  input  wire logic [1:0] action,
  input  wire logic       top_bit,
  input  wire t2w_ev_s    ev,
  // Result
  output logic            wave,
  output logic            connected
);

  logic wave_r;
  logic wave_nxt;
  logic toggle_ok;
  logic hi_ignored;

  // Code 0,1 toggles in PWM only on channel A with top bit set
  assign toggle_ok  = (cls == T2W_CLS_NONPWM) || (IS_CHAN_A && top_bit);
  assign hi_ignored = action[1] && ev.cmp_is_top;
  assign connected  = action[1] || (action[0] && toggle_ok);
  assign wave       = wave_r;

  // Next output level from class, action and events
  always_comb begin
    wave_nxt = wave_r;
    if (ev.tick) begin
      case (cls)
        T2W_CLS_NONPWM: begin
          if (ev.match) begin
            case (action)
              T2W_ACT_TOGGLE: wave_nxt = ~wave_r;
              T2W_ACT_CLEAR:  wave_nxt = 1'b0;
              T2W_ACT_SET:    wave_nxt = 1'b1;
              default:        wave_nxt = wave_r;
            endcase
          end
        end
        T2W_CLS_FAST: begin
          if (action[1]) begin
            if (ev.at_bottom) begin
              wave_nxt = ~action[0];
            end else if (ev.match && !hi_ignored) begin
              wave_nxt = action[0];
            end
          end else if (action == T2W_ACT_TOGGLE && toggle_ok && ev.match) begin
            wave_nxt = ~wave_r;
          end
        end
        T2W_CLS_PHASE: begin
          if (action[1]) begin
            if (hi_ignored) begin
              if (ev.at_top) begin
                wave_nxt = ~action[0];
              end
            end else if (ev.match) begin
              wave_nxt = ev.up ? action[0] : ~action[0];
            end
          end else if (action == T2W_ACT_TOGGLE && toggle_ok && ev.match) begin
            wave_nxt = ~wave_r;
          end
        end
        default: wave_nxt = wave_r;
      endcase
    end
  end

  // Output level register
  always_ff @(posedge clk) begin
    if (reset) begin
      wave_r <= 1'b0;
    end else begin
      wave_r <= wave_nxt;
    end
  end

endmodule
`default_nettype wire

// file: logic/t2w_timer2_wave.sv
// Timer2 counter, waveform modes, compare outputs and AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module t2w_timer2_wave
  import t2w_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Compare output pins
  output logic             compare_out_a,
  output logic             compare_out_a_oe,
  output logic             compare_out_b,
  output logic             compare_out_b_oe,
  // Interrupt
  output logic             irq
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] wave_ctrl_r;
  logic       top_bit_r;
  logic       run_r;
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic       up_r;
  logic       up_nxt;
  logic [7:0] cmp_a_buf_r;
  logic [7:0] cmp_b_buf_r;
  logic [7:0] cmp_a_r;
  logic [7:0] cmp_b_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic [3:0] pin_ctrl_r;
  logic       wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] hrdata_r;

  // Writable bits of the wave control register; 3:2 stay zero
  localparam logic [7:0] WAVE_WR_MASK = 8'hf3;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic        addr_phase;
  logic        wr_now;
  logic [7:0]  wdat;
  logic [31:0] rd_val;
  logic [7:0]  a_ofs;

  function automatic logic hit(input logic [7:0] ofs, input logic [7:0] target);
    hit = (ofs == target);
  endfunction

  // One count step up or down, wrapping at the byte boundary
  function automatic logic [7:0] count_step(input logic [7:0] v, input logic up);
    count_step = up ? v + 8'h01 : v - 8'h01;
  endfunction

  // Counting class of a mode code; reserved codes 4 and 6 act as non-PWM
  function automatic t2w_class_e mode_class(input logic [2:0] m);
    if (m == 3'd3 || m == 3'd7) begin
      mode_class = T2W_CLS_FAST;
    end else if (m == 3'd1 || m == 3'd5) begin
      mode_class = T2W_CLS_PHASE;
    end else begin
      mode_class = T2W_CLS_NONPWM;
    end
  endfunction

  // Address phase taken when selected, ready and NONSEQ or SEQ
  assign addr_phase = hsel && hready && htrans[1];
  assign a_ofs      = haddr[7:0];
  assign wr_now     = wr_pend_r;
  assign wdat       = hwdata[7:0];
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_r;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  logic [2:0]  mode;
  t2w_class_e  cls;
  logic        top_is_cmp;
  logic [7:0]  top_val;
  logic [1:0]  act_a;
  logic [1:0]  act_b;

  assign mode       = {top_bit_r, wave_ctrl_r[T2W_F_LOW_BITS +: 2]};
  assign cls        = mode_class(mode);
  assign top_is_cmp = (mode == 3'd2) || (mode == 3'd5) || (mode == 3'd7);
  assign top_val    = top_is_cmp ? cmp_a_r : T2W_MAX;
  assign act_a      = wave_ctrl_r[T2W_F_ACT_A +: 2];
  assign act_b      = wave_ctrl_r[T2W_F_ACT_B +: 2];

  // ****************************************************************
  // Counter events
  // ****************************************************************
  logic tick;
  logic at_top;
  logic at_bottom;
  logic load_cmp;
  logic ovf_ev;
  logic cnt_wr;

  assign tick      = run_r;
  assign at_top    = (count_r == top_val);
  assign at_bottom = (count_r == T2W_BOTTOM);
  assign cnt_wr    = wr_now && hit(wr_addr_r, T2W_OFS_COUNT);

  // Buffered compare values load at TOP in PWM modes, else at once
  assign load_cmp = (cls == T2W_CLS_NONPWM) ? 1'b1 : (tick && at_top);

  // Overflow flag point per mode
  assign ovf_ev = tick && (
                    (cls == T2W_CLS_PHASE)  ? (at_bottom && !up_r) :
                    (cls == T2W_CLS_FAST)   ? at_top :
                                              (count_r == T2W_MAX));

  // Next count and direction
  always_comb begin
    count_nxt = count_r;
    up_nxt    = up_r;
    if (tick) begin
      if (cls == T2W_CLS_PHASE) begin
        if (up_r && at_top) begin
          up_nxt    = 1'b0;
          count_nxt = count_step(count_r, 1'b0);
        end else if (!up_r && at_bottom) begin
          up_nxt    = 1'b1;
          count_nxt = count_step(count_r, 1'b1);
        end else begin
          count_nxt = count_step(count_r, up_r);
        end
      end else begin
        up_nxt    = 1'b1;
        count_nxt = at_top ? T2W_BOTTOM : count_step(count_r, 1'b1);
      end
    end
  end

  // Counter and direction register
  always_ff @(posedge clk) begin
    if (reset) begin
      count_r <= T2W_RST_BYTE;
      up_r    <= 1'b1;
    end else if (cnt_wr) begin
      count_r <= wdat;
      up_r    <= up_r;
    end else begin
      count_r <= count_nxt;
      up_r    <= up_nxt;
    end
  end

  // Active compare values
  always_ff @(posedge clk) begin
    if (reset) begin
      cmp_a_r <= T2W_RST_BYTE;
      cmp_b_r <= T2W_RST_BYTE;
    end else if (load_cmp) begin
      cmp_a_r <= cmp_a_buf_r;
      cmp_b_r <= cmp_b_buf_r;
    end
  end

  // ****************************************************************
  // Compare channels
  // ****************************************************************
  t2w_ev_s ev_a;
  t2w_ev_s ev_b;
  logic    wave_a;
  logic    wave_b;
  logic    conn_a;
  logic    conn_b;

  assign ev_a = '{tick: tick, match: (count_r == cmp_a_r), at_bottom: at_bottom,
                  at_top: at_top && up_r, up: up_r, cmp_is_top: (cmp_a_r == top_val)};
  assign ev_b = '{tick: tick, match: (count_r == cmp_b_r), at_bottom: at_bottom,
                  at_top: at_top && up_r, up: up_r, cmp_is_top: (cmp_b_r == top_val)};

  t2w_channel #(.IS_CHAN_A(1'b1)) u_chan_a (
    .clk       (clk),
    .reset     (reset),
    .cls       (cls),
    .action    (act_a),
    .top_bit   (top_bit_r),
    .ev        (ev_a),
    .wave      (wave_a),
    .connected (conn_a)
  );

  t2w_channel #(.IS_CHAN_A(1'b0)) u_chan_b (
    .clk       (clk),
    .reset     (reset),
    .cls       (cls),
    .action    (act_b),
    .top_bit   (top_bit_r),
    .ev        (ev_b),
    .wave      (wave_b),
    .connected (conn_b)
  );

  // Pin muxing: compare output or port data, driver by direction bit
  assign compare_out_a    = conn_a ? wave_a : pin_ctrl_r[T2W_F_PORT_A];
  assign compare_out_b    = conn_b ? wave_b : pin_ctrl_r[T2W_F_PORT_B];
  assign compare_out_a_oe = pin_ctrl_r[T2W_F_DIR_A];
  assign compare_out_b_oe = pin_ctrl_r[T2W_F_DIR_B];

  // ****************************************************************
  // Register writes
  // ****************************************************************
  logic [2:0] irq_ev;
  logic [2:0] irq_clr;

  assign irq_ev  = {tick && ev_b.match, tick && ev_a.match, ovf_ev};
  assign irq_clr = (wr_now && hit(wr_addr_r, T2W_OFS_IRQ_STAT)) ? wdat[2:0] : 3'b000;
  assign irq     = |(irq_stat_r & irq_mask_r);

  // Data phase tracking
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_phase && hwrite;
      wr_addr_r <= a_ofs;
    end
  end

  // Control registers; reserved bits 3:2 never stored
  always_ff @(posedge clk) begin
    if (reset) begin
      wave_ctrl_r <= T2W_RST_BYTE;
      top_bit_r   <= 1'b0;
      run_r       <= 1'b0;
      cmp_a_buf_r <= T2W_RST_BYTE;
      cmp_b_buf_r <= T2W_RST_BYTE;
      irq_mask_r  <= 3'b000;
      pin_ctrl_r  <= 4'h0;
    end else if (wr_now) begin
      if (hit(wr_addr_r, T2W_OFS_WAVE_CTRL)) begin
        wave_ctrl_r <= wdat & WAVE_WR_MASK;
      end else if (hit(wr_addr_r, T2W_OFS_CLK_CTRL)) begin
        top_bit_r <= wdat[T2W_F_TOP_BIT];
        run_r     <= wdat[T2W_F_RUN];
      end else if (hit(wr_addr_r, T2W_OFS_CMP_A)) begin
        cmp_a_buf_r <= wdat;
      end else if (hit(wr_addr_r, T2W_OFS_CMP_B)) begin
        cmp_b_buf_r <= wdat;
      end else if (hit(wr_addr_r, T2W_OFS_IRQ_MASK)) begin
        irq_mask_r <= wdat[2:0];
      end else if (hit(wr_addr_r, T2W_OFS_PIN_CTRL)) begin
        pin_ctrl_r <= wdat[3:0];
      end
    end
  end

  // Sticky status: a new event wins over a write-one clear
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_stat_r <= 3'b000;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  assign rd_val =
    hit(a_ofs, T2W_OFS_WAVE_CTRL) ? {24'h0, wave_ctrl_r & WAVE_WR_MASK} :
    hit(a_ofs, T2W_OFS_CLK_CTRL)  ? {24'h0, 4'h0, top_bit_r, 2'b00, run_r} :
    hit(a_ofs, T2W_OFS_COUNT)     ? {24'h0, count_r} :
    hit(a_ofs, T2W_OFS_CMP_A)     ? {24'h0, cmp_a_buf_r} :
    hit(a_ofs, T2W_OFS_CMP_B)     ? {24'h0, cmp_b_buf_r} :
    hit(a_ofs, T2W_OFS_IRQ_STAT)  ? {29'h0, irq_stat_r} :
    hit(a_ofs, T2W_OFS_IRQ_MASK)  ? {29'h0, irq_mask_r} :
    hit(a_ofs, T2W_OFS_PIN_CTRL)  ? {28'h0, pin_ctrl_r} : 32'h0;

  // Read data captured at the address phase
  always_ff @(posedge clk) begin
    if (reset) begin
      hrdata_r <= 32'h0;
    end else if (addr_phase && !hwrite) begin
      hrdata_r <= rd_val;
    end
  end

endmodule
`default_nettype wire

// file: testbench/t2w_timer2_wave_props.sv
// Checker: bus shadows and pin properties of the timer2 waveform block
`timescale 1ns/1ps
`default_nettype none
module t2w_props
  import t2w_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // Pins and interrupt
  input wire logic        compare_out_a,
  input wire logic        compare_out_a_oe,
  input wire logic        compare_out_b,
  input wire logic        compare_out_b_oe,
  input wire logic        irq
);
  // ****************************************************************
  // Shadows of the control registers
  // ****************************************************************
  logic       dp_wr;
  logic       dp_rd;
  logic       top;
  logic       top_q;
  logic       steady;
  logic [7:0] dp_adr;
  logic [7:0] wc;
  logic [7:0] wc_q;
  logic [3:0] pc;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Data phase tracking and write capture
  always_ff @(posedge clk) begin
    if (reset) begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      wc    <= 8'h00;
      top   <= 1'b0;
      pc    <= 4'h0;
    end else begin
      if (hready) begin
        dp_wr  <= hsel & htrans[1] & hwrite;
        dp_rd  <= hsel & htrans[1] & ~hwrite;
        dp_adr <= haddr[7:0];
      end
      if (dp_wr && hready && dp_adr == T2W_OFS_WAVE_CTRL) begin
        wc <= hwdata[7:0];
      end
      if (dp_wr && hready && dp_adr == T2W_OFS_CLK_CTRL) begin
        top <= hwdata[T2W_F_TOP_BIT];
      end
      if (dp_wr && hready && dp_adr == T2W_OFS_PIN_CTRL) begin
        pc <= hwdata[3:0];
      end
    end
  end

  // Previous configuration, to skip the cycle of a change
  always_ff @(posedge clk) begin
    wc_q  <= wc;
    top_q <= top;
  end
  assign steady = (wc == wc_q) && (top == top_q);

  owner_a_a: assert property (steady && wc[7:6] == 2'b00 |-> compare_out_a == pc[2])
    else $error("pin A not on port data");
  owner_b_a: assert property (steady && wc[5:4] == 2'b00 |-> compare_out_b == pc[3])
    else $error("pin B not on port data");
  drive_a_a: assert property (compare_out_a_oe == pc[0])
    else $error("pin A enable wrong");
  drive_b_a: assert property (compare_out_b_oe == pc[1])
    else $error("pin B enable wrong");
  rsvd_zero_a: assert property (dp_rd && dp_adr == T2W_OFS_WAVE_CTRL |-> hrdata[3:2] == 2'b00)
    else $error("reserved bits read nonzero");
  a_pwm_off_a: assert property (steady && wc[0] && !top && wc[7:6] == 2'b01 |-> compare_out_a == pc[2])
    else $error("pin A connected with code 1");
  b_pwm_off_a: assert property (steady && wc[0] && wc[5:4] == 2'b01 |-> compare_out_b == pc[3])
    else $error("pin B connected with code 1");
  clr_no_rise_a: assert property (steady && !wc[0] && wc[7:6] == 2'b10 |-> !$rose(compare_out_a))
    else $error("clear action raised pin A");
  set_no_fall_a: assert property (steady && !wc[0] && wc[5:4] == 2'b11 |-> !$fell(compare_out_b))
    else $error("set action lowered pin B");

  // Main scenarios
  cover property (dp_rd && dp_adr == T2W_OFS_WAVE_CTRL);
  cover property ($rose(compare_out_a));
  cover property (irq);
endmodule
`default_nettype wire

// file: testbench/t2w_timer2_wave_bench.sv
// Bench: register access, pin ownership and waveform sequences of the timer2 waveform block
`timescale 1ns/1ps
`default_nettype none
module t2w_timer2_wave_bench
  import t2w_pkg::*;
;
  // ****************************************************************
  // Stimulus, tasks and sequence
  // ****************************************************************
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        compare_out_a;
  logic        compare_out_a_oe;
  logic        compare_out_b;
  logic        compare_out_b_oe;
  logic        irq;
  logic [31:0] rdat;
  logic [31:0] clk_sel = 32'h0;
  logic [1:0]  codes [4] = '{2'b01, 2'b10, 2'b11, 2'b01};
  logic [3:0]  waves = 4'b0101;
  int          num_errors = 0;
  int          checked = 0;

  // Clock and bus ready
  always #5 clk = ~clk;
  assign hready = hreadyout;

  t2w_timer2_wave dut (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .compare_out_a(compare_out_a), .compare_out_a_oe(compare_out_a_oe),
    .compare_out_b(compare_out_b), .compare_out_b_oe(compare_out_b_oe), .irq(irq)
  );

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait for the ready edge
  task automatic hwait();
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      if (n == 50) begin
        num_errors++;
        $display("[ERR] %0t bus wait timed out", $time);
        end_of_test();
      end
      n++;
      @(posedge clk);
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'b10;
    hwait();
    htrans <= 2'b00;
    hwdata <= d;
    hwait();
    rdat = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    check(rdat, e);
  endtask

  // Counter runs for a stretch, then stops
  task automatic go(input int n);
    wr(T2W_OFS_CLK_CTRL, clk_sel | 32'h1);
    repeat (n) @(posedge clk);
    wr(T2W_OFS_CLK_CTRL, clk_sel);
  endtask

  task automatic run(input logic [7:0] s, input int n);
    wr(T2W_OFS_COUNT, {24'h0, s});
    go(n);
  endtask

  // Pins as {b, a, b enable, a enable}, sampled at the falling edge
  task automatic pins(input logic [3:0] e);
    @(negedge clk);
    check({28'h0, compare_out_b, compare_out_a, compare_out_b_oe, compare_out_a_oe}, {28'h0, e});
    @(posedge clk);
  endtask

  task automatic irqis(input logic e);
    @(negedge clk);
    check({31'h0, irq}, {31'h0, e});
    @(posedge clk);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int a = 0; a <= 32; a += 4) begin
      rd(8'(a), 32'h0);
    end
    wr(T2W_OFS_WAVE_CTRL, 32'hff);
    rd(T2W_OFS_WAVE_CTRL, 32'hf3);
    wr(T2W_OFS_CLK_CTRL, 32'h08);
    rd(T2W_OFS_CLK_CTRL, 32'h08);
    wr(T2W_OFS_WAVE_CTRL, 32'h00);
    wr(T2W_OFS_CLK_CTRL, 32'h00);
    wr(T2W_OFS_PIN_CTRL, 32'h0c);
    pins(4'b1100);
    wr(T2W_OFS_PIN_CTRL, 32'h03);
    pins(4'b0011);
    $display("registers and pins done");
    wr(T2W_OFS_CMP_A, 32'h10);
    wr(T2W_OFS_CMP_B, 32'h10);
    for (int i = 0; i < 4; i++) begin
      wr(T2W_OFS_WAVE_CTRL, {24'h0, codes[i], codes[i], 4'h0});
      run(8'h0e, 20);
      pins({waves[i], waves[i], 2'b11});
    end
    rd(T2W_OFS_IRQ_STAT, 32'h06);
    irqis(1'b0);
    wr(T2W_OFS_IRQ_MASK, 32'h02);
    irqis(1'b1);
    wr(T2W_OFS_IRQ_STAT, 32'h02);
    rd(T2W_OFS_IRQ_STAT, 32'h04);
    irqis(1'b0);
    wr(T2W_OFS_IRQ_MASK, 32'h04);
    irqis(1'b1);
    wr(T2W_OFS_IRQ_STAT, 32'h04);
    irqis(1'b0);
    $display("non-PWM and interrupt done");
    wr(T2W_OFS_WAVE_CTRL, 32'h02);
    wr(T2W_OFS_CMP_B, 32'h20);
    run(8'h00, 40);
    rd(T2W_OFS_IRQ_STAT, 32'h02);
    wr(T2W_OFS_IRQ_STAT, 32'h07);
    wr(T2W_OFS_WAVE_CTRL, 32'h00);
    run(8'hfe, 10);
    rd(T2W_OFS_IRQ_STAT, 32'h01);
    wr(T2W_OFS_CMP_A, 32'h80);
    wr(T2W_OFS_CMP_B, 32'h80);
    for (int i = 0; i < 2; i++) begin
      wr(T2W_OFS_WAVE_CTRL, {24'h0, 1'b1, 1'(i), 1'b1, 1'(i), 4'h3});
      run(8'hfe, 10);
      pins({~1'(i), ~1'(i), 2'b11});
      run(8'h7c, 12);
      pins({1'(i), 1'(i), 2'b11});
    end
    wr(T2W_OFS_PIN_CTRL, 32'h0f);
    wr(T2W_OFS_WAVE_CTRL, 32'h53);
    run(8'h7c, 12);
    pins(4'b1111);
    $display("modes and fast PWM done");
    reset <= 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    wr(T2W_OFS_PIN_CTRL, 32'h03);
    wr(T2W_OFS_CMP_A, 32'h80);
    wr(T2W_OFS_CMP_B, 32'h80);
    wr(T2W_OFS_WAVE_CTRL, 32'hb1);
    run(8'hf0, 160);
    pins(4'b0111);
    go(200);
    pins(4'b0111);
    go(60);
    pins(4'b1011);
    rd(T2W_OFS_IRQ_STAT, 32'h07);
    $display("phase-correct PWM done");
    wr(T2W_OFS_WAVE_CTRL, 32'h00);
    wr(T2W_OFS_CMP_A, 32'h40);
    wr(T2W_OFS_CMP_B, 32'h40);
    clk_sel = 32'h08;
    wr(T2W_OFS_WAVE_CTRL, 32'h71);
    run(8'h00, 100);
    pins(4'b0111);
    wr(T2W_OFS_WAVE_CTRL, 32'h73);
    run(8'h3e, 1);
    pins(4'b0011);
    wr(T2W_OFS_WAVE_CTRL, 32'h63);
    go(1);
    pins(4'b1011);
    $display("top-bit modes done");
    end_of_test();
  end
endmodule

bind t2w_timer2_wave t2w_props u_props (
  .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .compare_out_a(compare_out_a), .compare_out_a_oe(compare_out_a_oe),
  .compare_out_b(compare_out_b), .compare_out_b_oe(compare_out_b_oe), .irq(irq)
);
`default_nettype wire
